/* File: hdl/jfrc_top.sv */
// Purpose: read-side instruction decode for a scan-reached dual_clock_queue
// Assumes: scan signals are produced on tck; queue read side runs on ref_clk
// Notes:   tck may stop between scans; crossings are toggle and level based
`timescale 1ns/1ps
module jfrc_top (
    // queue read clock and reset
    input  wire logic                           ref_clk,
    input  wire logic                           reset,
    // scan side, clocked by tck
    input  wire logic                           tck,
    input  wire logic                           tck_reset,
    input  wire logic                           tdi,
    input  wire logic [jfrc_pkg::IR_WIDTH-1:0]  ir_in,
    input  wire jfrc_pkg::jfrc_scan_state_type  scan_state,
    output logic                                tdo,
    // queue read side
    input  wire jfrc_pkg::jfrc_queue_status_type queue_status,
    output logic                                queue_read_req,
    output logic                                drain_active
);
    import jfrc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // instruction decode (tck domain)
    ////////////////////////////////////////////////////////////////////////
    wire is_read_one = (ir_in == INSTR_READ_ONE);
    wire is_drain    = (ir_in == INSTR_DRAIN);
    wire is_rev_id   = (ir_in == INSTR_REV_ID);       // revision select

    logic [DATA_WIDTH-1:0] value_chain;               // read value scan chain
    logic [REV_WIDTH-1:0]  rev_chain;                 // revision word chain
    logic                  bypass_bit;                // one-stage bypass
    logic                  read_toggle;               // read event, tck side
    logic                  drain_toggle;              // drain event, tck side
    logic [DATA_WIDTH-1:0] queue_data_tck;            // data synchronised
    logic [DATA_WIDTH-1:0] queue_data_meta;           // first stage only

    // queue data into tck domain before capture
    // hazard: the word crosses with no handshake; this is safe only because
    // the head word stays still for many tck cycles before a capture, and
    // the pop that this block launches lands well after the scan that read it
    // limitation: a word that changes within two tck edges of capture may tear
    always_ff @(posedge tck) begin
        queue_data_meta <= queue_status.data;
        queue_data_tck  <= queue_data_meta;
    end

    // value chain: parallel load then shift toward tdo
    // loads the word present at capture; the pop follows at update
    always_ff @(posedge tck) begin
        if (tck_reset) begin
            value_chain <= '0;
        end else if (is_read_one && scan_state.capture_dr) begin
            value_chain <= queue_data_tck;
        end else if (is_read_one && scan_state.shift_dr) begin
            value_chain <= {tdi, value_chain[DATA_WIDTH-1:1]};
        end
    end

    // revision word chain
    always_ff @(posedge tck) begin
        if (tck_reset) begin
            rev_chain <= '0;
        end else if (is_rev_id && scan_state.capture_dr) begin
            rev_chain <= REV_ID_DEFAULT;
        end else if (is_rev_id && scan_state.shift_dr) begin
            rev_chain <= {tdi, rev_chain[REV_WIDTH-1:1]};
        end
    end

    // bypass stage keeps tdi to tdo continuity
    // cleared on capture so the first bit out is a known zero
    always_ff @(posedge tck) begin
        if (tck_reset) begin
            bypass_bit <= 1'b0;
        end else if (scan_state.capture_dr) begin
            bypass_bit <= 1'b0;
        end else if (scan_state.shift_dr) begin
            bypass_bit <= tdi;
        end
    end

    // one read event per update-dr under read-single
    always_ff @(posedge tck) begin
        if (tck_reset) begin
            read_toggle <= 1'b0;
        end else if (is_read_one && scan_state.update_dr) begin
            read_toggle <= ~read_toggle;
        end
    end

    // drain starts on the instruction update alone
    // a repeat while draining is absorbed by the phase machine
    // no data scan is needed, so update-ir is the only trigger
    always_ff @(posedge tck) begin
        if (tck_reset) begin
            drain_toggle <= 1'b0;
        end else if (scan_state.update_ir && is_drain) begin
            drain_toggle <= ~drain_toggle;
        end
    end

    // tdo mux
    wire next_tdo = is_read_one ? value_chain[0] :
                    is_rev_id   ? rev_chain[0]   :
                    bypass_bit;

    // register tdo so the output comes from a flop
    // falling-edge update gives the host half a tck of setup
    always_ff @(negedge tck) begin
        if (tck_reset) begin
            tdo <= 1'b0;
        end else begin
            tdo <= next_tdo;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // crossing into the read clock
    ////////////////////////////////////////////////////////////////////////
    // toggles cross instead of pulses: tck may stop right after update,
    // so a one-tck pulse could be missed, while a level change is always seen
    // hazard: a tck-side reset mid-run may flip a toggle and fake one event
    // limitation: read-singles need at least three read clocks between them
    logic read_toggle_sync;                           // synchronised toggle
    logic drain_toggle_sync;                          // synchronised toggle
    logic read_toggle_seen;                           // last seen value
    logic drain_toggle_seen;                          // last seen value

    jfrc_sync u_read_sync (
        .clk       (ref_clk),
        .reset     (reset),
        .level_in  (read_toggle),
        .level_out (read_toggle_sync)
    );

    jfrc_sync u_drain_sync (
        .clk       (ref_clk),
        .reset     (reset),
        .level_in  (drain_toggle),
        .level_out (drain_toggle_sync)
    );

    logic empty_sync;                                 // empty flag, own clock
    jfrc_sync u_empty_sync (
        .clk       (ref_clk),
        .reset     (reset),
        .level_in  (queue_status.empty),
        .level_out (empty_sync)
    );

    // each event lasts one cycle: the seen copy catches up on the next edge
    wire read_event  = read_toggle_sync ^ read_toggle_seen;
    wire drain_event = drain_toggle_sync ^ drain_toggle_seen;

    ////////////////////////////////////////////////////////////////////////
    // read request generation (ref_clk domain)
    ////////////////////////////////////////////////////////////////////////
    // drain phases in gray order
    // limitation: empty arrives through two flops and the request is registered, so a drain
    // may over-read for three cycles; the queue must ignore reads while it is empty
    // a drain asked for while empty is already seen is refused
    typedef enum logic [1:0] {
        JFRC_IDLE     = 2'b00,                        // no drain
        JFRC_DRAINING = 2'b01                         // request held
    } jfrc_drain_state_type;

    jfrc_drain_state_type drain_state;                // current phase
    jfrc_drain_state_type next_drain_state;           // next phase

    // drain phase transitions
    always_comb begin
        next_drain_state = drain_state;
        case (drain_state)
            JFRC_IDLE: begin
                if (drain_event && !empty_sync) begin
                    next_drain_state = JFRC_DRAINING;
                end
            end
            JFRC_DRAINING: begin
                if (empty_sync) begin
                    next_drain_state = JFRC_IDLE;
                end
            end
            default: begin
                next_drain_state = JFRC_IDLE;
            end
        endcase
    end

    wire next_draining = (next_drain_state == JFRC_DRAINING);
    wire next_read_req = next_draining | read_event;

    // state, edge memory and outputs
    // drain_active mirrors the phase so the far side can watch the burst
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            drain_state       <= JFRC_IDLE;
            read_toggle_seen  <= 1'b0;
            drain_toggle_seen <= 1'b0;
            queue_read_req    <= 1'b0;
            drain_active      <= 1'b0;
        end else begin
            drain_state       <= next_drain_state;
            read_toggle_seen  <= read_toggle_sync;
            drain_toggle_seen <= drain_toggle_sync;
            queue_read_req    <= next_read_req;
            drain_active      <= next_draining;
        end
    end

endmodule : jfrc_top

/* File: hdl/jfrc_pkg.sv */
// Purpose: shared constants and carriers for the scan-side queue read control
// Assumes: three-bit user instruction register, byte-wide queue data
// Notes:   instruction codes and the revision word are plain defaults
package jfrc_pkg;
    localparam int unsigned IR_WIDTH    = 3;          // user instruction width
    localparam int unsigned DATA_WIDTH  = 8;          // queue word width
    localparam int unsigned REV_WIDTH   = 32;         // revision word width
    localparam int unsigned SYNC_STAGES = 2;          // flops per synchroniser

    // instruction codes
    localparam logic [2:0] INSTR_WRITE_ONE = 3'h1;    // write one value
    localparam logic [2:0] INSTR_READ_ONE  = 3'h2;    // read one value
    localparam logic [2:0] INSTR_DRAIN     = 3'h3;    // drain until empty
    localparam logic [2:0] INSTR_REV_ID    = 3'h4;    // shift out revision word

    // revision word default, value arbitrary
    localparam logic [31:0] REV_ID_DEFAULT = 32'h0000_0001;

    // scan-side state indications from the tap
    typedef struct packed {
        logic capture_dr;                             // virtual capture-dr
        logic shift_dr;                               // virtual shift-dr
        logic update_dr;                              // virtual update-dr
        logic update_ir;                              // virtual update-ir
    } jfrc_scan_state_type;

    // read side of the dual_clock_queue
    typedef struct packed {
        logic       empty;                            // queue reports empty
        logic [7:0] data;                             // queue output word
    } jfrc_queue_status_type;
endpackage : jfrc_pkg

/* File: hdl/jfrc_sync.sv */
// Purpose: two-flop level synchroniser into the destination clock
// Assumes: input is a level held long enough to be seen
// Notes:   first flop feeds only the second flop
`timescale 1ns/1ps
module jfrc_sync (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // level in and out
    input  wire logic level_in,
    output logic      level_out
);
    import jfrc_pkg::*;

    logic [SYNC_STAGES-1:0] stage;                    // synchroniser chain

    // shift the level through the chain
    always_ff @(posedge clk) begin
        if (reset) begin
            stage <= '0;
        end else begin
            stage <= {stage[SYNC_STAGES-2:0], level_in};
        end
    end

    assign level_out = stage[SYNC_STAGES-1];
endmodule : jfrc_sync

/* File: testbench/jfrc_top_asserts.sv */
// Purpose: port-level checker for the scan-side queue read control
// Assumes: both resets synchronous and active high
// Notes:   bound to every jfrc_top instance
`timescale 1ns/1ps
module jfrc_asserts (
    // clocks and resets
    input wire logic                            ref_clk,
    input wire logic                            reset,
    input wire logic                            tck,
    input wire logic                            tck_reset,
    // scan side
    input wire logic                            tdi,
    input wire logic [jfrc_pkg::IR_WIDTH-1:0]   ir_in,
    input wire jfrc_pkg::jfrc_scan_state_type   scan_state,
    input wire logic                            tdo,
    // queue side
    input wire jfrc_pkg::jfrc_queue_status_type queue_status,
    input wire logic                            queue_read_req,
    input wire logic                            drain_active
);
    import jfrc_pkg::*;
    ////////////////////////////////////////////////////////////////////////////////
    // queue domain
    property p_read_pulse; @(posedge ref_clk) disable iff (reset)
        queue_read_req && !drain_active |=> !queue_read_req; endproperty
    a_read_pulse: assert property (p_read_pulse) else $error("read pulse too long");
    property p_read_issue; @(posedge ref_clk) disable iff (reset)
        $rose(scan_state.update_dr) && ir_in == INSTR_READ_ONE |-> ##[1:12] queue_read_req;
    endproperty
    a_read_issue: assert property (p_read_issue) else $error("no read pulse");
    property p_drain_start; @(posedge ref_clk) disable iff (reset)
        $rose(scan_state.update_ir) && ir_in == INSTR_DRAIN && !queue_status.empty
        |-> ##[1:12] drain_active; endproperty
    a_drain_start: assert property (p_drain_start) else $error("drain not started");
    property p_drain_holds; @(posedge ref_clk) disable iff (reset)
        drain_active |-> queue_read_req; endproperty
    a_drain_holds: assert property (p_drain_holds) else $error("drain request dropped");
    property p_drain_stays; @(posedge ref_clk) disable iff (reset)
        (drain_active && !queue_status.empty)[*3] |=> drain_active; endproperty
    a_drain_stays: assert property (p_drain_stays) else $error("drain ended early");
    property p_drain_release; @(posedge ref_clk) disable iff (reset)
        drain_active && queue_status.empty |-> ##[1:6] !drain_active; endproperty
    a_drain_release: assert property (p_drain_release) else $error("drain stuck");
    property p_drain_end; @(posedge ref_clk) disable iff (reset)
        $fell(drain_active) |-> !queue_read_req; endproperty
    a_drain_end: assert property (p_drain_end) else $error("request after drain");
    ////////////////////////////////////////////////////////////////////////////////
    // scan domain: one-stage bypass while draining
    property p_bypass; @(posedge tck) disable iff (tck_reset)
        $past(scan_state.shift_dr) && ir_in == INSTR_DRAIN |-> tdo == $past(tdi); endproperty
    a_bypass: assert property (p_bypass) else $error("bypass path broken");
    // main scenarios reached
    c_read: cover property (@(posedge ref_clk) disable iff (reset) $rose(queue_read_req));
    c_drain: cover property (@(posedge ref_clk) disable iff (reset) $fell(drain_active));
    c_shift: cover property (@(posedge tck) disable iff (tck_reset) scan_state.shift_dr);
endmodule : jfrc_asserts
bind jfrc_top jfrc_asserts jfrc_asserts_inst (.ref_clk(ref_clk), .reset(reset), .tck(tck),
    .tck_reset(tck_reset), .tdi(tdi), .ir_in(ir_in), .scan_state(scan_state), .tdo(tdo),
    .queue_status(queue_status), .queue_read_req(queue_read_req), .drain_active(drain_active));

/* File: testbench/jfrc_host.sv */
// Purpose: scan host model shifting instruction and data scans
// Assumes: tck period 48 ns, resting low between frames
// Notes:   tdi shows the inverse of its last bit once released
`timescale 1ns/1ps
module jfrc_host (
    // scan outputs toward the block
    output logic                           tck,
    output logic                           tdi,
    output logic [jfrc_pkg::IR_WIDTH-1:0]  ir_in,
    output jfrc_pkg::jfrc_scan_state_type  scan_state,
    // scan data back
    input  wire logic                      tdo
);
    import jfrc_pkg::*;
    initial begin
        tck = 1'b0;
        tdi = 1'b0;
        ir_in = '0;
        scan_state = '0;
    end
    // n full tck cycles, ending low
    task automatic pulse(input int n);
        repeat (n) begin
            #24 tck = 1'b1;
            #24 tck = 1'b0;
        end
    endtask : pulse
    // instruction scan, no data scan follows for drain
    task automatic ir_scan(input logic [2:0] code);
        ir_in = code;
        scan_state.update_ir = 1'b1;
        pulse(1);
        scan_state.update_ir = 1'b0;
    endtask : ir_scan
    // capture, n shifts lsb first, update
    task automatic dr_scan(input logic [31:0] din, input int n, output logic [31:0] dout);
        dout = '0;
        scan_state.capture_dr = 1'b1;
        pulse(1);
        scan_state.capture_dr = 1'b0;
        scan_state.shift_dr = 1'b1;
        for (int i = 0; i < n; i++) begin
            tdi = din[i];
            #24 dout[i] = tdo;
            tck = 1'b1;
            #24 tck = 1'b0;
        end
        scan_state.shift_dr = 1'b0;
        scan_state.update_dr = 1'b1;
        tdi = ~tdi;
        pulse(1);
        scan_state.update_dr = 1'b0;
    endtask : dr_scan
endmodule : jfrc_host

/* File: testbench/jfrc_top_tb_top.sv */
// Purpose: self-checking bench for the queue read control
// Assumes: ref_clk 8 ns; host model owns tck
// Notes:   queue side modelled by bench levels
`timescale 1ns/1ps
module jfrc_top_tb_top;
    import jfrc_pkg::*;
    logic                  ref_clk, reset, tck_reset, tck, tdi, tdo, queue_read_req, drain_active;
    logic [2:0]            ir_in;
    jfrc_scan_state_type   scan_state;
    jfrc_queue_status_type queue_status;
    logic [31:0]           got;
    int                    error_cnt, n_tests, pulses;
    jfrc_top jfrc_top_inst (.ref_clk(ref_clk), .reset(reset), .tck(tck), .tck_reset(tck_reset),
        .tdi(tdi), .ir_in(ir_in), .scan_state(scan_state), .tdo(tdo), .queue_status(queue_status),
        .queue_read_req(queue_read_req), .drain_active(drain_active));
    jfrc_host jfrc_host_inst (.tck(tck), .tdi(tdi), .ir_in(ir_in), .scan_state(scan_state),
        .tdo(tdo));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // cycles with the read request high
    always @(posedge ref_clk) if (queue_read_req === 1'b1) pulses++;
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] act);
        n_tests++;
        if (act !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, act);
        end
    endtask : check
    task automatic give_verdict;
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    // read-single: byte out lsb first, one pulse
    task automatic read_one(input logic [7:0] val);
        queue_status = {1'b0, val};
        pulses = 0;
        jfrc_host_inst.ir_scan(INSTR_READ_ONE);
        jfrc_host_inst.pulse(2);
        jfrc_host_inst.dr_scan(32'h0, 8, got);
        repeat (20) @(negedge ref_clk);
        check("read byte", {24'h0, val}, got);
        check("read pulses", 32'h1, pulses);
    endtask : read_one
    // write-single: bypass only, no read
    task automatic write_one;
        pulses = 0;
        jfrc_host_inst.ir_scan(INSTR_WRITE_ONE);
        jfrc_host_inst.dr_scan(32'h96, 8, got);
        repeat (20) @(negedge ref_clk);
        check("write bypass", 32'h2c, got);
        check("write pulses", 32'h0, pulses);
    endtask : write_one
    // drain until empty, bypass meanwhile, refused when empty
    task automatic drain;
        jfrc_host_inst.ir_scan(INSTR_DRAIN);
        repeat (20) @(negedge ref_clk);
        check("drain start", 32'h1, drain_active);
        jfrc_host_inst.dr_scan(32'h96, 8, got);
        check("drain bypass", 32'h2c, got);
        check("drain held", 32'h1, queue_read_req);
        queue_status.empty = 1'b1;
        repeat (8) @(negedge ref_clk);
        check("drain stop", 32'h0, {drain_active, queue_read_req});
        pulses = 0;
        jfrc_host_inst.ir_scan(INSTR_DRAIN);
        repeat (20) @(negedge ref_clk);
        check("drain refused", 32'h0, pulses);
    endtask : drain
    initial begin
        reset = 1'b1;
        tck_reset = 1'b1;
        queue_status = {1'b1, 8'h00};
        error_cnt = 0;
        n_tests = 0;
        repeat (6) @(negedge ref_clk);
        reset = 1'b0;
        jfrc_host_inst.pulse(2);
        tck_reset = 1'b0;
        check("idle outputs", 32'h0, {queue_read_req, drain_active, tdo});
        read_one(8'ha5);
        read_one(8'h3c);
        write_one();
        jfrc_host_inst.ir_scan(INSTR_REV_ID);
        jfrc_host_inst.dr_scan(32'h0, 32, got);
        check("revision word", REV_ID_DEFAULT, got);
        drain();
        give_verdict();
    end
    // hang guard
    initial begin
        #100000;
        error_cnt++;
        give_verdict();
    end
endmodule : jfrc_top_tb_top
